// ===== tb/ocmd_channel_tb.sv
/*
 Self-checking bench for the channel-five output mux and divider.
 Assumes registers at index*4 byte addresses; ack is awaited with no fixed latency.
*/
`timescale 1ns/1ps
module ocmd_channel_tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic [3:0] sel_i = 4'h0;
	logic we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, doubler_en_i = 1'b0;
	logic ack_o, chan_clk_o, out_p_o, out_p_oe_o, out_n_o, out_n_oe_o;
	logic [1:0] tail_sel_o, term_sel_o;
	ocmd_pkg::ocmd_drv_t drv_type_o;
	ocmd_pkg::ocmd_clk_in_t clk_in_i;
	logic [7:0] tick = 8'h00;
	logic [7:0] lfsr = 8'h4C;
	logic chan_q = 1'b0;
	int mismatches = 0, check_count = 0, per_cnt = 0, rises = 0;
	logic [31:0] rd_q[$];
	logic [31:0] per_q[$];
	logic [31:0] msk_q[$];

	// ----------------------------------------
	// clock, sources, design
	// ----------------------------------------
	initial forever #4 clk_i = ~clk_i;
	always @(posedge clk_i) tick <= tick + 8'h01;
	// periods in clk cycles: syn1 4, syn2 8, pri 16, sec 32, doubled refs half that
	assign clk_in_i = {tick[1], tick[2], tick[3], tick[4], tick[2], tick[3]};

	ocmd_channel dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.ack_o(ack_o), .clk_in_i(clk_in_i), .doubler_en_i(doubler_en_i),
		.chan_clk_o(chan_clk_o), .drv_type_o(drv_type_o), .tail_sel_o(tail_sel_o),
		.term_sel_o(term_sel_o), .out_p_o(out_p_o), .out_p_oe_o(out_p_oe_o),
		.out_n_o(out_n_o), .out_n_oe_o(out_n_oe_o));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	function automatic logic [7:0] nxt(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	function automatic logic pv(input logic [1:0] m, input logic c);
		return (m == 2'b11) ? c : ((m == 2'b10) ? ~c : 1'b0);
	endfunction

	task automatic wb(input logic [7:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d);
		@(posedge clk_i);
		adr_i <= a;
		we_i <= w;
		sel_i <= s;
		dat_i <= d;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		// only the watchdog bounds this wait
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		rd_q.push_back({24'h0, exp});
		msk_q.push_back(32'hFFFF_FFFF);
		wb(a, 1'b0, 4'hF, 32'h0);
	endtask

	// status bit 3 follows the running channel clock, so it is masked off
	task automatic rd_st(input logic [2:0] exp);
		rd_q.push_back({29'h0, exp});
		msk_q.push_back(32'hFFFF_FFF7);
		wb(8'hA4, 1'b0, 4'hF, 32'h0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(a, 1'b1, 4'h1, {24'hA5A5A5, d});
	endtask

	task automatic wait_rises(input int n);
		int s;
		s = rises;
		while (rises < s + n)
			@(posedge clk_i);
	endtask

	// pins lag the channel clock by one cycle
	task automatic pins(input logic [1:0] mp, input logic [1:0] mn);
		logic c;
		@(posedge clk_i);
		#1 c = chan_clk_o;
		@(posedge clk_i);
		#1;
		check(32'(out_p_oe_o), 32'(mp != 2'b00));
		check(32'(out_n_oe_o), 32'(mn != 2'b00));
		if (mp != 2'b00) check(32'(out_p_o), 32'(pv(mp, c)));
		if (mn != 2'b00) check(32'(out_n_o), 32'(pv(mn, c)));
	endtask

	// ----------------------------------------
	// output monitor
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && rd_q.size() > 0)
			check(dat_o & msk_q.pop_front(), rd_q.pop_front());
		chan_q <= chan_clk_o;
		per_cnt <= per_cnt + 1;
		if (chan_clk_o === 1'b1 && chan_q === 1'b0) begin
			if (per_q.size() > 0)
				check(32'(per_cnt), per_q.pop_front());
			per_cnt <= 1;
			rises <= rises + 1;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [1:0] s;
		logic [7:0] d;
		int b;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h9C, ocmd_pkg::CTL_RST);
		rd(8'hA0, ocmd_pkg::DIV_RST);
		check(32'({drv_type_o, tail_sel_o, term_sel_o}), 32'h18);
		wr(8'hB0, 8'hFF);
		rd(8'hB0, 8'h00);
		wb(8'hA0, 1'b1, 4'h0, 32'h55);
		rd(8'hA0, 8'h02);
		// syn1 ratio 1 and 256 ride on the last two cases
		for (int k = 0; k < 8; k++) begin
			lfsr = nxt(lfsr);
			s = (k < 4) ? k[1:0] : ((k < 6) ? k[1:0] + 2'd2 : 2'd0);
			d = (k == 6) ? 8'h00 : ((k == 7) ? 8'hFF : {6'h0, lfsr[1:0]});
			doubler_en_i <= (k == 4 || k == 5);
			b = (s == 2'd0) ? 4 : ((s == 2'd1) ? 8 : ((s == 2'd2) ? 16 : 32));
			if (k == 4 || k == 5) b = b / 2;
			wr(8'hA0, d);
			wr(8'h9C, {s, 6'b111110});
			wait_rises(3);
			per_q.push_back((s < 2'd2) ? b * (d + 1) : b);
			wait_rises(2);
			rd(8'h9C, {s, 6'b111110});
			rd_st({1'b0, s});
		end
		for (int m = 0; m < 4; m++) begin
			wr(8'h9C, {2'b00, 2'b11, m[1:0], 2'(3 - m)});
			pins(m[1:0], 2'(3 - m));
		end
		wr(8'h9C, 8'h6E);
		// ratio 256 boundary lies far ahead, so the new source must still wait
		rd_st(3'h4);
		pins(2'b11, 2'b10);
		check(32'({drv_type_o, tail_sel_o, term_sel_o}), 32'h2E);
		wr(8'h9C, 8'h0E);
		@(posedge clk_i);
		#1 check(32'({out_p_oe_o, out_n_oe_o}), 32'h0);
		end_of_test();
	end

	initial begin
		#(8 * 40000);
		mismatches++;
		end_of_test();
	end
endmodule

// ===== verilog/ocmd_channel.sv
/*
 Channel-five output logic: Wishbone register slave, source mux, output divider and
 driver pin control. Source clocks are sampled levels synchronous to clk_i and must be
 well below half its rate; the divider counts their rising edges.
*/
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
module ocmd_channel (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic [3:0] sel_i,
	input wire logic we_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	input wire ocmd_pkg::ocmd_clk_in_t clk_in_i,
	input wire logic doubler_en_i,
	output logic chan_clk_o,
	output ocmd_pkg::ocmd_drv_t drv_type_o,
	output logic [1:0] tail_sel_o,
	output logic [1:0] term_sel_o,
	output logic out_p_o,
	output logic out_p_oe_o,
	output logic out_n_o,
	output logic out_n_oe_o
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] idx);
		reg_hit = (a == 8'(idx << ocmd_pkg::IDX_SHIFT));
	endfunction

	function automatic logic pin_drive(input logic [1:0] m, input logic clk);
		case (m)
			ocmd_pkg::PIN_INV: pin_drive = ~clk;
			ocmd_pkg::PIN_NONINV: pin_drive = clk;
			default: pin_drive = 1'b0;
		endcase
	endfunction

	ocmd_pkg::ocmd_bus_t bus_st_r;
	ocmd_pkg::ocmd_ctl_t ctl_r;
	ocmd_pkg::ocmd_src_t act_src_r;
	logic [7:0] div_r;
	logic [7:0] act_div_r;
	logic [7:0] cnt_r;
	logic [7:0] cnt_nxt;
	logic [7:0] half;
	logic [31:0] dat_r;
	logic src_lvl;
	logic src_d_r;
	logic rise;
	logic bypass;
	logic boundary;
	logic pending;
	logic chan_clk_r;
	logic req;
	logic wr_ctl;
	logic wr_div;

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	// one wait state: ack one cycle after the request is seen, then idle for a cycle
	assign req = cyc_i && stb_i;
	assign ack_o = (bus_st_r == ocmd_pkg::BUS_ACK) && req;
	assign wr_ctl = ack_o && we_i && sel_i[0] && reg_hit(adr_i, ocmd_pkg::CTL_IDX);
	assign wr_div = ack_o && we_i && sel_i[0] && reg_hit(adr_i, ocmd_pkg::DIV_IDX);
	assign dat_o = dat_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_st_r <= ocmd_pkg::BUS_IDLE;
		end else begin
			case (bus_st_r)
				ocmd_pkg::BUS_IDLE: begin
					if (req) begin
						bus_st_r <= ocmd_pkg::BUS_ACK;
					end
				end
				ocmd_pkg::BUS_ACK: bus_st_r <= ocmd_pkg::BUS_IDLE;
				default: bus_st_r <= ocmd_pkg::BUS_IDLE;
			endcase
		end
	end

	// read data is captured while idle so it is steady when ack rises
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= ocmd_pkg::RD_ZERO;
		end else if (bus_st_r == ocmd_pkg::BUS_IDLE && req) begin
			dat_r <= ocmd_pkg::RD_ZERO;
			if (reg_hit(adr_i, ocmd_pkg::CTL_IDX)) begin
				dat_r[7:0] <= ctl_r;
			end else if (reg_hit(adr_i, ocmd_pkg::DIV_IDX)) begin
				dat_r[7:0] <= div_r;
			end else if (reg_hit(adr_i, ocmd_pkg::STAT_IDX)) begin
				dat_r[3:0] <= {chan_clk_r, pending, act_src_r};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_r <= ocmd_pkg::CTL_RST;
		end else if (wr_ctl) begin
			ctl_r <= dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= ocmd_pkg::DIV_RST;
		end else if (wr_div) begin
			div_r <= dat_i[7:0];
		end
	end

	// ----------------------------------------
	// source mux
	// ----------------------------------------
	always_comb begin
		case (act_src_r)
			ocmd_pkg::SRC_SYN1: src_lvl = clk_in_i.syn1;
			ocmd_pkg::SRC_SYN2: src_lvl = clk_in_i.syn2;
			ocmd_pkg::SRC_PRI: src_lvl = doubler_en_i ? clk_in_i.pri_dbl : clk_in_i.pri;
			ocmd_pkg::SRC_SEC: src_lvl = doubler_en_i ? clk_in_i.sec_dbl : clk_in_i.sec;
			default: src_lvl = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_d_r <= 1'b0;
		end else begin
			src_d_r <= src_lvl;
		end
	end

	assign rise = src_lvl && !src_d_r;
	assign bypass = act_src_r[1];
	assign boundary = rise && (bypass || cnt_r == act_div_r);
	assign pending = (ctl_r.src != act_src_r) || (div_r != act_div_r);
	assign cnt_nxt = boundary ? 8'h00 : cnt_r + 8'h01;
	// high for the first ceil(ratio/2) source periods
	assign half = 8'(({1'b0, act_div_r} + 9'h002) >> 1);

	// ----------------------------------------
	// glitch-free update of source and ratio
	// ----------------------------------------
	// a source that stops never reaches a boundary, so a pending change waits for it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_src_r <= ocmd_pkg::SRC_SYN1;
			act_div_r <= ocmd_pkg::DIV_RST;
		end else if (boundary) begin
			act_src_r <= ctl_r.src;
			act_div_r <= div_r;
		end
	end

	// ----------------------------------------
	// divider
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 8'h00;
		end else if (rise) begin
			cnt_r <= bypass ? 8'h00 : cnt_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_clk_r <= 1'b0;
		end else if (bypass || act_div_r == 8'h00) begin
			chan_clk_r <= src_lvl;
		end else if (rise) begin
			chan_clk_r <= (cnt_nxt < half);
		end
	end

	assign chan_clk_o = chan_clk_r;

	// ----------------------------------------
	// driver control
	// ----------------------------------------
	assign drv_type_o = ctl_r.drv;
	assign tail_sel_o = ctl_r.mode_pri;
	assign term_sel_o = ctl_r.mode_sec;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_p_o <= 1'b0;
			out_p_oe_o <= 1'b0;
			out_n_o <= 1'b0;
			out_n_oe_o <= 1'b0;
		end else begin
			case (ctl_r.drv)
				ocmd_pkg::DRV_CMOS: begin
					out_p_o <= pin_drive(ctl_r.mode_pri, chan_clk_r);
					out_p_oe_o <= (ctl_r.mode_pri != ocmd_pkg::PIN_TRI);
					out_n_o <= pin_drive(ctl_r.mode_sec, chan_clk_r);
					out_n_oe_o <= (ctl_r.mode_sec != ocmd_pkg::PIN_TRI);
				end
				ocmd_pkg::DRV_ACDIFF, ocmd_pkg::DRV_HCSL: begin
					out_p_o <= chan_clk_r;
					out_p_oe_o <= 1'b1;
					out_n_o <= ~chan_clk_r;
					out_n_oe_o <= 1'b1;
				end
				default: begin
					out_p_o <= 1'b0;
					out_p_oe_o <= 1'b0;
					out_n_o <= 1'b0;
					out_n_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_wrap;
		rise && !bypass && cnt_r == act_div_r;
	endsequence

	sequence s_hold;
		!boundary;
	endsequence

	property p_syn2_route;
		act_src_r == ocmd_pkg::SRC_SYN2 |-> src_lvl == clk_in_i.syn2;
	endproperty
	a_syn2_route: assert property (p_syn2_route)
		else $error("second synthesizer not routed");

	property p_dbl_route;
		doubler_en_i && act_src_r == ocmd_pkg::SRC_SEC |-> src_lvl == clk_in_i.sec_dbl;
	endproperty
	a_dbl_route: assert property (p_dbl_route)
		else $error("doubled reference not routed");

	property p_bypass;
		bypass && $past(bypass) |=> chan_clk_o == $past(src_lvl);
	endproperty
	a_bypass: assert property (p_bypass)
		else $error("reference not passed undivided");

	property p_wrap;
		s_wrap |=> cnt_r == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("divider did not wrap at ratio");

	property p_div_write;
		wr_div |=> div_r == $past(dat_i[7:0]);
	endproperty
	a_div_write: assert property (p_div_write)
		else $error("divider field not written");

	property p_div_hold;
		!bypass && act_div_r != 8'h00 && !rise |=> $stable(chan_clk_o);
	endproperty
	a_div_hold: assert property (p_div_hold)
		else $error("divided clock moved without source edge");

	property p_boundary_only;
		s_hold |=> $stable(act_src_r) && $stable(act_div_r);
	endproperty
	a_boundary_only: assert property (p_boundary_only)
		else $error("settings changed off a boundary");

	property p_off;
		ctl_r.drv == ocmd_pkg::DRV_OFF |=> !out_p_oe_o && !out_n_oe_o;
	endproperty
	a_off: assert property (p_off)
		else $error("disabled output still driven");

	property p_cmos_p_inv;
		ctl_r.drv == ocmd_pkg::DRV_CMOS && ctl_r.mode_pri == ocmd_pkg::PIN_INV
			|=> out_p_oe_o && out_p_o == !$past(chan_clk_o);
	endproperty
	a_cmos_p_inv: assert property (p_cmos_p_inv)
		else $error("positive pin not inverted");

	property p_cmos_n_low;
		ctl_r.drv == ocmd_pkg::DRV_CMOS && ctl_r.mode_sec == ocmd_pkg::PIN_LOW
			|=> out_n_oe_o && !out_n_o;
	endproperty
	a_cmos_n_low: assert property (p_cmos_n_low)
		else $error("negative pin not driven low");

endmodule

// ===== verilog/ocmd_pkg.sv
/*
 Constants, types and register layout of the channel-five output source mux and divider.
 Assumes a single 125 MHz clock and a classic Wishbone master with 8-bit byte addresses.
*/
package ocmd_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] CTL_IDX = 8'h27;
	localparam logic [7:0] DIV_IDX = 8'h28;
	localparam logic [7:0] STAT_IDX = 8'h29;
	localparam int IDX_SHIFT = 2;
	localparam logic [7:0] CTL_RST = 8'h18;
	localparam logic [7:0] DIV_RST = 8'h02;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// field encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRC_SYN1 = 2'b00,
		SRC_SYN2 = 2'b01,
		SRC_PRI = 2'b10,
		SRC_SEC = 2'b11
	} ocmd_src_t;

	typedef enum logic [1:0] {
		DRV_OFF = 2'b00,
		DRV_ACDIFF = 2'b01,
		DRV_HCSL = 2'b10,
		DRV_CMOS = 2'b11
	} ocmd_drv_t;

	typedef enum logic [1:0] {
		PIN_TRI = 2'b00,
		PIN_LOW = 2'b01,
		PIN_INV = 2'b10,
		PIN_NONINV = 2'b11
	} ocmd_pin_t;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} ocmd_bus_t;

	// control register layout, msb first: bits 7:6, 5:4, 3:2, 1:0
	typedef struct packed {
		ocmd_src_t src;
		ocmd_drv_t drv;
		logic [1:0] mode_pri;
		logic [1:0] mode_sec;
	} ocmd_ctl_t;

	typedef struct packed {
		logic syn1;
		logic syn2;
		logic pri;
		logic sec;
		logic pri_dbl;
		logic sec_dbl;
	} ocmd_clk_in_t;

endpackage
